// ===== dls_pkg.sv
// package: lane status register map, field positions and reset values
package dls_pkg;
   // ***************************************************************
   // bank shape
   // ***************************************************************
   localparam int NUM_LANES = 9;
   localparam int NUM_RANKS = 4;
   localparam int PERIOD_W = 8;
   localparam int CODE_W = 4;
   localparam int CAL_FLAGS = 5;
   localparam int CAL_HOLD_CYCLES = 2;
   // ***************************************************************
   // address map: lane n word0 at WORD0_OFS + n*LANE_STRIDE
   // ***************************************************************
   localparam logic [11:0] LANE_STRIDE = 12'h0010;
   localparam logic [11:0] WORD0_OFS = 12'h0000;
   localparam logic [11:0] WORD2_OFS = 12'h0008;
   localparam logic [11:0] CTRL_OFS = 12'h0100;
   // ***************************************************************
   // word0 fields
   // ***************************************************************
   localparam int W0_WL_DQ_CAPTURE = 28;
   localparam int W0_GATE_ERR_LSB = 24;
   localparam int W0_GATE_PERIOD_LSB = 16;
   localparam int W0_PLL_LOCKED = 15;
   localparam int W0_WL_PERIOD_LSB = 7;
   localparam int W0_WL_ERROR = 6;
   localparam int W0_WL_DONE = 5;
   localparam int W0_CAL_LSB = 0;
   // ***************************************************************
   // word2 fields
   // ***************************************************************
   localparam int W2_CODE_LSB = 8;
   localparam int W2_EYE_LSB = 4;
   localparam int W2_DESKEW_LSB = 0;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : dls_pkg

// ===== dls_lane_if.sv
// interface: one lane's training results from engine side to register side
`timescale 1ns/1ps
interface dls_lane_if;
   logic wl_dq_capture;
   logic [3:0] gate_train_err;
   logic [7:0] gate_period;
   logic lane_pll_locked;
   logic [7:0] wl_period;
   logic wl_error;
   logic wl_done_a;
   logic [4:0] cal_done;
   logic [3:0] train_err_code;
   logic [3:0] eye_flags;
   logic [3:0] deskew_flags;
   logic [31:0] word0;
   logic [31:0] word2;
   modport src (output wl_dq_capture, gate_train_err, gate_period, lane_pll_locked,
      wl_period, wl_error, wl_done_a, cal_done, train_err_code, eye_flags, deskew_flags);
   modport lane (input wl_dq_capture, gate_train_err, gate_period, lane_pll_locked,
      wl_period, wl_error, wl_done_a, cal_done, train_err_code, eye_flags, deskew_flags,
      output word0, word2);
   modport rd (input word0, word2);
endinterface : dls_lane_if

// ===== dls_lane_regs.sv
// module: status words of one data byte lane
`timescale 1ns/1ps
module dls_lane_regs
   import dls_pkg::*;
#(
   parameter bit HAS_STROBE_N = 1'b1
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cal_release,
   dls_lane_if.lane lif
);
   logic [31:0] word0_reg;
   logic [31:0] word2_reg;
   logic [31:0] word0_next;
   logic [31:0] word2_next;
   logic [CAL_FLAGS-1:0] cal_mask;
   logic [CAL_FLAGS-1:0] cal_live;
   // ***************************************************************
   // word assembly
   // ***************************************************************
   // inverted strobe flag only exists in the complementary strobe variant
   assign cal_mask = HAS_STROBE_N ? 5'b1_1111 : 5'b1_1011;
   assign cal_live = lif.cal_done & cal_mask & {CAL_FLAGS{~cal_release}};
   always_comb
   begin
      word0_next = STATUS_RESET;
      word0_next[W0_WL_DQ_CAPTURE] = lif.wl_dq_capture;
      word0_next[W0_GATE_ERR_LSB +: NUM_RANKS] = lif.gate_train_err;
      word0_next[W0_GATE_PERIOD_LSB +: PERIOD_W] = lif.gate_period;
      word0_next[W0_PLL_LOCKED] = lif.lane_pll_locked;
      word0_next[W0_WL_PERIOD_LSB +: PERIOD_W] = lif.wl_period;
      word0_next[W0_WL_ERROR] = lif.wl_error;
      word0_next[W0_WL_DONE] = lif.wl_done_a;
      // bit4 wl, bit3 gate, bit2 strobe_n, bit1 strobe, bit0 write data
      word0_next[W0_CAL_LSB +: CAL_FLAGS] = cal_live;
      word2_next = STATUS_RESET;
      word2_next[W2_CODE_LSB +: CODE_W] = lif.train_err_code;
      word2_next[W2_EYE_LSB +: 4] = lif.eye_flags;
      word2_next[W2_DESKEW_LSB +: 4] = lif.deskew_flags;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         word0_reg <= STATUS_RESET;
         word2_reg <= STATUS_RESET;
      end
      else
      begin
         word0_reg <= word0_next;
         word2_reg <= word2_next;
      end
   end
   assign lif.word0 = word0_reg;
   assign lif.word2 = word2_reg;
endmodule : dls_lane_regs

// ===== dls_status_bank.sv
// module: APB status bank for all data byte lanes
`timescale 1ns/1ps
module dls_status_bank
   import dls_pkg::*;
#(
   parameter int LANES = NUM_LANES,
   parameter bit HAS_STROBE_N = 1'b1
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LANES-1:0] wl_dq_capture,
   input wire logic [LANES*NUM_RANKS-1:0] gate_train_err,
   input wire logic [LANES*PERIOD_W-1:0] gate_period,
   input wire logic [LANES-1:0] lane_pll_locked,
   input wire logic [LANES*PERIOD_W-1:0] wl_period,
   input wire logic [LANES-1:0] wl_error,
   input wire logic [LANES-1:0] wl_done_a,
   input wire logic [LANES*CAL_FLAGS-1:0] cal_done,
   input wire logic [LANES*CODE_W-1:0] train_err_code,
   input wire logic [LANES*4-1:0] eye_flags,
   input wire logic [LANES*4-1:0] deskew_flags,
   output logic [LANES*PERIOD_W-1:0] wl_period_ctl,
   output logic cal_all_done
);
   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (LANES < 1 || LANES > 15)
   begin : g_bad_lanes
      $error("LANES must be 1 to 15");
   end
   // ***************************************************************
   // per-lane registers
   // ***************************************************************
   logic [LANES-1:0] lane_all_done;
   logic [LANES*32-1:0] word0_flat;
   logic [LANES*32-1:0] word2_flat;
   logic cal_release_reg;
   logic [1:0] hold_cnt_reg;
   logic [1:0] hold_cnt_next;
   logic all_done_now;
   logic [4:0] req_mask;
   assign req_mask = HAS_STROBE_N ? 5'b1_1111 : 5'b1_1011;
   for (genvar i = 0; i < LANES; i++)
   begin : g_lane
      dls_lane_if lif ();
      assign lif.wl_dq_capture = wl_dq_capture[i];
      assign lif.gate_train_err = gate_train_err[i*NUM_RANKS +: NUM_RANKS];
      assign lif.gate_period = gate_period[i*PERIOD_W +: PERIOD_W];
      assign lif.lane_pll_locked = lane_pll_locked[i];
      assign lif.wl_period = wl_period[i*PERIOD_W +: PERIOD_W];
      assign lif.wl_error = wl_error[i];
      assign lif.wl_done_a = wl_done_a[i];
      assign lif.cal_done = cal_done[i*CAL_FLAGS +: CAL_FLAGS];
      assign lif.train_err_code = train_err_code[i*CODE_W +: CODE_W];
      assign lif.eye_flags = eye_flags[i*4 +: 4];
      assign lif.deskew_flags = deskew_flags[i*4 +: 4];
      dls_lane_regs #(
         .HAS_STROBE_N(HAS_STROBE_N)
      ) u_regs (
         .clk(clk),
         .reset_n(reset_n),
         .cal_release(cal_release_reg),
         .lif(lif)
      );
      assign word0_flat[i*32 +: 32] = lif.word0;
      assign word2_flat[i*32 +: 32] = lif.word2;
      assign lane_all_done[i] = &(cal_done[i*CAL_FLAGS +: CAL_FLAGS] | ~req_mask);
   end
   // ***************************************************************
   // calibration done release
   // ***************************************************************
   // flags are shown for at least two cycles once all lanes report done,
   // then released; release ends when engines drop their done lines
   assign all_done_now = &lane_all_done;
   always_comb
   begin
      hold_cnt_next = hold_cnt_reg;
      if (!all_done_now)
         hold_cnt_next = 2'd0;
      else if (hold_cnt_reg != 2'(CAL_HOLD_CYCLES))
         hold_cnt_next = hold_cnt_reg + 2'd1;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hold_cnt_reg <= 2'd0;
         cal_release_reg <= 1'b0;
         cal_all_done <= 1'b0;
      end
      else
      begin
         hold_cnt_reg <= hold_cnt_next;
         cal_release_reg <= all_done_now && hold_cnt_next == 2'(CAL_HOLD_CYCLES);
         cal_all_done <= all_done_now && hold_cnt_next == 2'(CAL_HOLD_CYCLES);
      end
   end
   // ***************************************************************
   // write leveling pipeline control
   // ***************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wl_period_ctl <= '0;
      else
         wl_period_ctl <= wl_period;
   end
   // ***************************************************************
   // apb slave: one wait-free access phase, read-only bank
   // ***************************************************************
   logic [3:0] lane_sel;
   logic [3:0] word_sel;
   logic lane_hit;
   logic w0_hit;
   logic w2_hit;
   logic ctrl_hit;
   logic access;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_word;
   assign lane_sel = paddr[7:4];
   assign word_sel = paddr[3:0];
   assign lane_hit = paddr[11:8] == 4'h0 && 32'(lane_sel) < LANES;
   assign w0_hit = lane_hit && {8'h00, word_sel} == WORD0_OFS;
   assign w2_hit = lane_hit && {8'h00, word_sel} == WORD2_OFS;
   assign ctrl_hit = paddr == CTRL_OFS;
   assign access = psel && penable;
   assign ctrl_word = {30'h0000_0000, cal_release_reg, all_done_now};
   always_comb
   begin
      rd_mux = UNMAPPED_DATA;
      for (int k = 0; k < LANES; k++)
      begin
         if (32'(lane_sel) == k && w0_hit)
            rd_mux = word0_flat[k*32 +: 32];
         if (32'(lane_sel) == k && w2_hit)
            rd_mux = word2_flat[k*32 +: 32];
      end
      if (ctrl_hit)
         rd_mux = ctrl_word;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // ready rises in the first access cycle, so transfers take two cycles
         pready <= psel && !penable;
         pslverr <= psel && !penable && (pwrite || !(w0_hit || w2_hit || ctrl_hit));
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
   logic unused_ok;
   assign unused_ok = ^{pwdata, access};
endmodule : dls_status_bank

// ===== dls_bank_monitor.sv
// checker: port relations of the lane status bank
`timescale 1ns/1ps
module dls_bank_monitor
   import dls_pkg::*;
#(
   parameter int LANES = NUM_LANES,
   parameter bit HAS_STROBE_N = 1'b1
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [LANES*PERIOD_W-1:0] wl_period,
   input wire logic [LANES*CAL_FLAGS-1:0] cal_done,
   input wire logic [LANES*PERIOD_W-1:0] wl_period_ctl,
   input wire logic cal_all_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire logic setup = psel && !penable;
   wire logic rd = setup && !pwrite;
   // inverted strobe flag is not awaited where the variant lacks it
   localparam logic [CAL_FLAGS-1:0] OPT_FLAGS = HAS_STROBE_N ? 5'b0_0000 : 5'b0_0100;
   wire logic all_in = &(cal_done | {LANES{OPT_FLAGS}});
   property p_ready; setup |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_cause; pready |-> $past(setup); endproperty
   a_cause: assert property (p_cause) else $error("stray ready");
   property p_wr; setup && pwrite |=> pslverr && prdata == '0; endproperty
   a_wr: assert property (p_wr) else $error("write not refused");
   property p_hole; rd && paddr == 12'h004 |=> pslverr && prdata == '0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read");
   property p_lane8; rd && paddr == 12'h080 |=> !pslverr; endproperty
   a_lane8: assert property (p_lane8) else $error("lane 8 refused");
   property p_quiet; !pready |-> prdata == '0 && !pslverr; endproperty
   a_quiet: assert property (p_quiet) else $error("data outside access");
   property p_ctl; $past(reset_n, 2) |-> wl_period_ctl == $past(wl_period); endproperty
   a_ctl: assert property (p_ctl) else $error("period control lag");
   property p_rel; $rose(cal_all_done) |-> $past(all_in) && $past(all_in, 2); endproperty
   a_rel: assert property (p_rel) else $error("early release");
   property p_w2; rd && paddr[3:0] == 4'h8 |=> prdata[31:12] == '0; endproperty
   a_w2: assert property (p_w2) else $error("reserved bits set");
   property p_nostrobe; !HAS_STROBE_N && rd && paddr[3:0] == 4'h0 |=> !prdata[2]; endproperty
   a_nostrobe: assert property (p_nostrobe) else $error("strobe_n flag shown");
   c_read: cover property (rd ##1 pready);
   c_write: cover property (setup && pwrite ##1 pslverr);
   c_rel: cover property ($rose(cal_all_done));
endmodule : dls_bank_monitor

// ===== test_dls_status_bank.sv
// testbench: lane status bank read-back, refusal and calibration release
`timescale 1ns/1ps
module test_dls_status_bank;
   import dls_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, cal_all_done, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [NUM_LANES-1:0] wl_dq_capture = '0, lane_pll_locked = '0, wl_error = '0, wl_done_a = '0;
   logic [NUM_LANES*4-1:0] gate_train_err = '0, train_err_code = '0, eye_flags = '0;
   logic [NUM_LANES*4-1:0] deskew_flags = '0;
   logic [NUM_LANES*8-1:0] gate_period = '0, wl_period = '0, wl_period_ctl;
   logic [NUM_LANES*5-1:0] cal_done = '0;
   logic alt_pready, alt_pslverr, alt_cal_all_done, alt_er;
   logic [31:0] alt_prdata, alt_rd;
   int mismatches = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   dls_status_bank dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wl_dq_capture(wl_dq_capture), .gate_train_err(gate_train_err),
      .gate_period(gate_period), .lane_pll_locked(lane_pll_locked), .wl_period(wl_period),
      .wl_error(wl_error), .wl_done_a(wl_done_a), .cal_done(cal_done),
      .train_err_code(train_err_code), .eye_flags(eye_flags), .deskew_flags(deskew_flags),
      .wl_period_ctl(wl_period_ctl), .cal_all_done(cal_all_done));
   // second bank without the complementary read strobe path
   dls_status_bank #(.HAS_STROBE_N(1'b0)) dut_nostrobe (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(alt_prdata), .pready(alt_pready), .pslverr(alt_pslverr),
      .wl_dq_capture(wl_dq_capture), .gate_train_err(gate_train_err),
      .gate_period(gate_period), .lane_pll_locked(lane_pll_locked), .wl_period(wl_period),
      .wl_error(wl_error), .wl_done_a(wl_done_a), .cal_done(cal_done),
      .train_err_code(train_err_code), .eye_flags(eye_flags), .deskew_flags(deskew_flags),
      .wl_period_ctl(), .cal_all_done(alt_cal_all_done));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= 32'hFFFF_FFFF;
      @(posedge clk);
      penable <= 1'b1;
      for (int n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge clk);
      if (pready !== 1'b1)
      begin
         mismatches++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      alt_rd = alt_pready ? alt_prdata : 32'hFFFF_FFFF;
      alt_er = alt_pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_rel(input logic v);
      for (int n = 0; n < 50 && cal_all_done !== v; n++)
         @(posedge clk);
      chk({31'h0, cal_all_done}, {31'h0, v});
   endtask : wait_rel
   function automatic logic [31:0] w0(int i, logic [4:0] c);
      return {3'b000, i[0], i[3:0], 8'h10 + 8'(i), 1'b1, 8'hA0 - 8'(i), i[1], ~i[0], c};
   endfunction : w0
   task automatic t_reset;
      apb(1'b0, 12'h000);
      chk(rd, STATUS_RESET);
      apb(1'b0, 12'h088);
      chk(rd, STATUS_RESET);
   endtask : t_reset
   task automatic t_fields;
      @(posedge clk);
      for (int i = 0; i < NUM_LANES; i++)
      begin
         wl_dq_capture[i] <= i[0];
         gate_train_err[i*4 +: 4] <= i[3:0];
         gate_period[i*8 +: 8] <= 8'h10 + 8'(i);
         lane_pll_locked[i] <= 1'b1;
         wl_period[i*8 +: 8] <= 8'hA0 - 8'(i);
         wl_error[i] <= i[1];
         wl_done_a[i] <= ~i[0];
         cal_done[i*5 +: 5] <= 5'h0A ^ i[4:0];
         train_err_code[i*4 +: 4] <= ~i[3:0];
         eye_flags[i*4 +: 4] <= i[3:0];
         deskew_flags[i*4 +: 4] <= 4'hF - i[3:0];
      end
      @(posedge clk);
      chk({31'h0, cal_all_done}, 32'h0000_0000);
      for (int i = 0; i < NUM_LANES; i++)
      begin
         apb(1'b0, 12'(i * 16));
         chk(rd, w0(i, 5'h0A ^ i[4:0]));
         chk(alt_rd, w0(i, (5'h0A ^ i[4:0]) & 5'h1B));
         apb(1'b0, 12'(i * 16 + 8));
         chk(rd, {20'h0_0000, ~i[3:0], i[3:0], 4'hF - i[3:0]});
      end
      chk(wl_period_ctl[71:40], wl_period[71:40]);
   endtask : t_fields
   task automatic t_refuse;
      apb(1'b1, 12'h030);
      chk({31'h0, er}, 32'h0000_0001);
      chk({31'h0, alt_er}, 32'h0000_0001);
      apb(1'b0, 12'h030);
      chk(rd, w0(3, 5'h09));
      apb(1'b0, 12'h004);
      chk({rd[30:0], er}, 32'h0000_0001);
      apb(1'b0, 12'h200);
      chk({rd[30:0], er}, 32'h0000_0001);
   endtask : t_refuse
   task automatic t_cal;
      @(posedge clk);
      cal_done <= '1;
      apb(1'b0, 12'h000);
      chk({27'h0, rd[4:0]}, 32'h0000_001F);
      wait_rel(1'b1);
      apb(1'b0, CTRL_OFS);
      chk(rd, 32'h0000_0003);
      apb(1'b0, 12'h050);
      chk(rd, w0(5, 5'h00));
      @(posedge clk);
      cal_done <= '0;
      wait_rel(1'b0);
   endtask : t_cal
   task automatic t_variant;
      @(posedge clk);
      cal_done <= {NUM_LANES{5'b1_1011}};
      apb(1'b0, 12'h010);
      chk(rd, w0(1, 5'h1B));
      chk(alt_rd, w0(1, 5'h1B));
      for (int n = 0; n < 50 && alt_cal_all_done !== 1'b1; n++)
         @(posedge clk);
      chk({31'h0, alt_cal_all_done}, 32'h0000_0001);
      chk({31'h0, cal_all_done}, 32'h0000_0000);
      apb(1'b0, 12'h010);
      chk(rd, w0(1, 5'h1B));
      chk(alt_rd, w0(1, 5'h00));
   endtask : t_variant
   initial
   begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_fields();
      t_refuse();
      t_cal();
      t_variant();
      end_sim();
   end
endmodule : test_dls_status_bank
bind dls_status_bank dls_bank_monitor #(.LANES(LANES), .HAS_STROBE_N(HAS_STROBE_N)) mon (
   .clk(clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .wl_period(wl_period), .cal_done(cal_done),
   .wl_period_ctl(wl_period_ctl), .cal_all_done(cal_all_done));
